// file: ecce_cycle_timer.sv
// Down counter that times one running operation
`timescale 1ns/1ps
`default_nettype none
module ecce_cycle_timer
   import ecce_pkg::*;
#(
   parameter int COUNT_W = 20
) (
   input  wire logic               core_clk,
   input  wire logic               nrst,
   input  wire logic               load,
   input  wire logic [COUNT_W-1:0] loadValue,
   output logic                    expired
);
   logic [COUNT_W-1:0] count_reg;

   // ===========================================
   // Counter: load wins, then count down to zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= '0;
         expired   <= 1'b0;
      end else if (load) begin
         count_reg <= loadValue;
         expired   <= 1'b0;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
         expired   <= (count_reg == {{(COUNT_W-1){1'b0}}, 1'b1});
      end else begin
         expired   <= 1'b0;
      end
   end
endmodule : ecce_cycle_timer
`default_nettype wire

// file: ecce_host_setup.sv
// Curve engine control port: APB registers, launch, busy flag, window addressing
`timescale 1ns/1ps
`default_nettype none
`include "ecce_map.svh"
module ecce_host_setup
   import ecce_pkg::*;
#(
   parameter int OP_CYCLES = `ECCE_OP_CYCLES,
   parameter int ADDR_W    = 32
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   output logic                   engineIrq,
   output logic                   wbEn,
   output logic      [ADDR_W-1:0] wbAddr,
   output logic      [31:0]       wbData,
   output logic      [ADDR_W-1:0] ptrAAddr,
   output logic      [ADDR_W-1:0] ptrBAddr,
   output logic      [ADDR_W-1:0] ptrCAddr
);
   // Elaboration checks: the count must fit the 20-bit timer, and the
   // base field is cut from one 32-bit bus word, so ADDR_W stops at 32
   if (OP_CYCLES < 2 || OP_CYCLES > 1048575) begin : gBadCycles
      $error("ecce_host_setup: OP_CYCLES out of range");
   end
   if (ADDR_W < 16 || ADDR_W > 32) begin : gBadAddrW
      $error("ecce_host_setup: ADDR_W out of range");
   end

   // ===========================================
   // Register state
   logic              clkEn_reg;
   logic [ADDR_W-1:0] base_reg;
   logic [31:0]       config_reg;
   logic              busy_reg;
   logic              done_reg;
   logic [7:0]        op_reg;
   ecce_state_e       state_reg;
   // Launch-time copies, so later writes cannot disturb a running job
   logic [ADDR_W-1:0] runBase_reg;
   logic [11:0]       runPtrs_reg;
   logic              runIrqEn_reg;
   logic [1:0]        runSize_reg;

   logic              access;
   logic              wrAcc;
   logic              launch;
   logic              timerExpired;
   logic              mapped;
   logic [31:0]       rdMux;

   assign access = psel && penable;
   assign wrAcc  = access && pwrite;
   // Launch only accepted when clocked and idle
   assign launch = wrAcc && (paddr == `ECCE_OFF_COMMAND) && clkEn_reg
                   && pwdata[`ECCE_CMD_START_BIT] && (state_reg == ECCE_IDLE);

   // ===========================================
   // Address decode for the APB slave
   // Unmapped offsets read zero and raise the error flag with ready
   always_comb begin
      mapped = 1'b1;
      rdMux  = 32'h0000_0000;
      unique case (paddr)
         `ECCE_OFF_CLKGATE:  rdMux = {31'h0, clkEn_reg};
         `ECCE_OFF_BASEADDR: rdMux = 32'(base_reg);
         `ECCE_OFF_CONFIG:   rdMux = config_reg;
         `ECCE_OFF_COMMAND:  rdMux = {16'h0, op_reg, 8'h0};
         `ECCE_OFF_STATUS:   rdMux = {30'h0, done_reg, busy_reg};
         `ECCE_OFF_IRQCLR:   rdMux = 32'h0000_0000;
         default:            mapped = 1'b0;
      endcase
   end

   // APB handshake: ready one cycle after setup, so every transfer is
   // wait-free; error only for offsets that decode to nothing
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Read data is captured in the setup cycle and held through access;
   // it reads zero outside a read so stale values never linger on the bus
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
      end
   end

   // ===========================================
   // Software-written control registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clkEn_reg  <= 1'b0;
         base_reg   <= '0;
         config_reg <= `ECCE_CFG_RESET;
         op_reg     <= 8'h00;
      end else if (wrAcc && pready) begin
         unique case (paddr)
            `ECCE_OFF_CLKGATE:  clkEn_reg <= pwdata[`ECCE_CLK_EN_BIT];
            // Low page bits forced to zero: 1 kB aligned window
            `ECCE_OFF_BASEADDR: base_reg <= {pwdata[ADDR_W-1:`ECCE_PAGE_BITS],
                                             {`ECCE_PAGE_BITS{1'b0}}};
            // Size field only takes 64/128/256 codes
            `ECCE_OFF_CONFIG: begin
               // Unused bits are dropped here so they always read back as zero
               config_reg <= pwdata & 32'h0001_3fff;
               if (pwdata[`ECCE_CFG_SIZE_LSB+:2] == 2'b11) begin
                  config_reg[`ECCE_CFG_SIZE_LSB+:2] <= ECCE_SZ256;
               end
            end
            `ECCE_OFF_COMMAND: if (launch) op_reg <= pwdata[`ECCE_CMD_OP_LSB+:8];
            default: ;
         endcase
      end
   end

   // ===========================================
   // Snapshot on launch
   // A write during a run reaches only clkEn_reg, config_reg and base_reg; the run keeps these copies
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         runBase_reg  <= '0;
         runPtrs_reg  <= 12'h000;
         runIrqEn_reg <= 1'b0;
         runSize_reg  <= 2'b00;
      end else if (launch && pready) begin
         runBase_reg  <= base_reg;
         runPtrs_reg  <= config_reg[11:0];
         runIrqEn_reg <= config_reg[`ECCE_CFG_IRQEN_BIT];
         runSize_reg  <= config_reg[`ECCE_CFG_SIZE_LSB+:2];
      end
   end

   // Operand addresses: base + pointer slot * slot size
   // The base keeps its low page bits zero, so the OR below acts as an addition
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ptrAAddr <= '0;
         ptrBAddr <= '0;
         ptrCAddr <= '0;
      end else begin
         ptrAAddr <= runBase_reg | ADDR_W'({runPtrs_reg[3:0], 5'h00});
         ptrBAddr <= runBase_reg | ADDR_W'({runPtrs_reg[7:4], 5'h00});
         ptrCAddr <= runBase_reg | ADDR_W'({runPtrs_reg[11:8], 5'h00});
      end
   end

   // ===========================================
   // Operation timer, about one curve operation long
   // Twenty bits hold the full default count; the check above guards overrides
   ecce_cycle_timer #(
      .COUNT_W (20)
   ) uTimer (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .load      (launch && pready),
      .loadValue (20'(OP_CYCLES)),
      .expired   (timerExpired)
   );

   // ===========================================
   // Sequencer: run, then write back r and s
   // No default: all four state codes are legal
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ECCE_IDLE;
      end else begin
         unique case (state_reg)
            ECCE_IDLE: if (launch && pready) state_reg <= ECCE_RUN;
            ECCE_RUN:  if (timerExpired) state_reg <= ECCE_WBR;
            ECCE_WBR:  state_reg <= ECCE_WBS;
            ECCE_WBS:  state_reg <= ECCE_IDLE;
         endcase
      end
   end

   // ===========================================
   // Result word store feeding the writeback port
   // Word R is written at launch straight from the request, word S
   // on every run cycle from the launch copies. Both are in place
   // before writeback starts, so the registered read lines up with
   // wbEn without an extra holding register.
   logic        slotWrEn;
   logic [3:0]  slotWrAddr;
   logic [31:0] slotWrData;
   logic [3:0]  slotRdAddr;
   logic [31:0] slotRdData;

   // Write and read selection; the read address leads writeback by one state
   always_comb begin
      slotWrEn   = 1'b0;
      slotWrAddr = `ECCE_SLOT_S;
      slotWrData = {22'h0, runSize_reg, op_reg};
      slotRdAddr = `ECCE_SLOT_S;
      if (launch && pready) begin
         slotWrEn   = 1'b1;
         slotWrAddr = `ECCE_SLOT_R;
         slotWrData = {22'h0, config_reg[`ECCE_CFG_SIZE_LSB+:2],
                       pwdata[`ECCE_CMD_OP_LSB+:8]};
      end else if (state_reg == ECCE_RUN) begin
         slotWrEn   = 1'b1;
      end
      if (state_reg == ECCE_RUN) begin
         slotRdAddr = `ECCE_SLOT_R;
      end
   end

   // Slot memory, sixteen words, one per window slot
   ecce_slot_store #(
      .DATA_W (32),
      .ADDR_W (4)
   ) uSlots (
      .core_clk (core_clk),
      .wrEn     (slotWrEn),
      .wrAddr   (slotWrAddr),
      .wrData   (slotWrData),
      .rdAddr   (slotRdAddr),
      .rdData   (slotRdData)
   );

   // Writeback port: one little-endian word per result slot, the
   // low word of each; width beyond 32 bits is padded by the host
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wbEn   <= 1'b0;
         wbAddr <= '0;
         wbData <= 32'h0000_0000;
      end else begin
         wbEn   <= (state_reg == ECCE_WBR) || (state_reg == ECCE_WBS);
         wbAddr <= runBase_reg | ADDR_W'({(state_reg == ECCE_WBR) ? `ECCE_SLOT_R
                                                                   : `ECCE_SLOT_S, 5'h00});
         // Zero outside writeback, so the data bus never shows a stale word
         wbData <= ((state_reg == ECCE_WBR) || (state_reg == ECCE_WBS)) ?
                   slotRdData : 32'h0000_0000;
      end
   end

   // ===========================================
   // Busy and done flags; launch sets busy, writeback clears it
   // Launch and writeback never meet, as launch needs the idle state
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         if (launch && pready) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
         end else if (state_reg == ECCE_WBS) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end else if (wrAcc && pready && paddr == `ECCE_OFF_IRQCLR) begin
            done_reg <= 1'b0;
         end
      end
   end

   // Completion pulse only when the engine-side enable was set; the
   // system controller's own enable lies outside this block
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         engineIrq <= 1'b0;
      end else begin
         engineIrq <= (state_reg == ECCE_WBS) && runIrqEn_reg;
      end
   end
endmodule : ecce_host_setup
`default_nettype wire

// file: ecce_host_setup_monitor.sv
// Port checker for the curve engine control port
`timescale 1ns/1ps
`default_nettype none
module ecce_host_setup_monitor
   import ecce_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic              engineIrq,
   input wire logic              wbEn,
   input wire logic [ADDR_W-1:0] wbAddr,
   input wire logic [31:0]       wbData,
   input wire logic [ADDR_W-1:0] ptrAAddr,
   input wire logic [ADDR_W-1:0] ptrBAddr,
   input wire logic [ADDR_W-1:0] ptrCAddr
);
   // ==========================================
   // Properties, all in the core clock domain
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Window is page aligned, so the low ten bits give the slot offset
   sequence s_wbR; wbEn && wbAddr[9:0] == 10'h140; endsequence
   sequence s_wbS; wbEn && wbAddr[9:0] == 10'h160; endsequence
   property p_wbPair; $rose(wbEn) |-> s_wbR ##1 s_wbS ##1 !wbEn; endproperty
   property p_rdySetup; psel && !penable |=> pready; endproperty
   property p_rdyPulse; pready |=> !pready; endproperty
   property p_rdyAccess; pready |-> psel && penable; endproperty
   property p_errRdy; pslverr |-> pready; endproperty
   property p_irqPulse; engineIrq |=> !engineIrq; endproperty
   // The pulse comes with the second writeback word, as busy falls
   property p_irqWb;
      engineIrq |-> wbEn && wbAddr[9:0] == 10'h160 && $past(wbEn);
   endproperty
   property p_ptrHold;
      wbEn |-> $stable(ptrAAddr) && $stable(ptrBAddr) && $stable(ptrCAddr);
   endproperty
   property p_wbDataIdle; !wbEn |-> wbData == 32'h0000_0000; endproperty
   a_wbPair: assert property (p_wbPair) else $error("writeback slots wrong");
   a_rdySetup: assert property (p_rdySetup) else $error("no ready after setup");
   a_rdyPulse: assert property (p_rdyPulse) else $error("ready too long");
   a_rdyAccess: assert property (p_rdyAccess) else $error("ready off access");
   a_errRdy: assert property (p_errRdy) else $error("error without ready");
   a_irqPulse: assert property (p_irqPulse) else $error("interrupt too long");
   a_irqWb: assert property (p_irqWb) else $error("interrupt not at writeback");
   a_ptrHold: assert property (p_ptrHold) else $error("pointer moved in run");
   a_wbDataIdle: assert property (p_wbDataIdle) else $error("data off writeback");
endmodule : ecce_host_setup_monitor

bind ecce_host_setup ecce_host_setup_monitor #(.ADDR_W(ADDR_W)) u_mon (.core_clk, .nrst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .engineIrq,
   .wbEn, .wbAddr, .wbData, .ptrAAddr, .ptrBAddr, .ptrCAddr);
`default_nettype wire

// file: ecce_map.svh
// Register offsets, field positions, reset values and timing counts of the curve engine port
`ifndef ECCE_MAP_SVH
`define ECCE_MAP_SVH

// Register block base and word offsets (byte addresses within the block)
`define ECCE_REG_BASE        32'h5000_6000
`define ECCE_UCODE_BASE      32'h4003_0000
`define ECCE_OFF_CLKGATE     12'h000
`define ECCE_OFF_BASEADDR    12'h004
`define ECCE_OFF_CONFIG      12'h008
`define ECCE_OFF_COMMAND     12'h00c
`define ECCE_OFF_STATUS      12'h010
`define ECCE_OFF_IRQCLR      12'h014

// Clock gate register fields
`define ECCE_CLK_EN_BIT      0

// Config register fields
`define ECCE_CFG_PTRA_LSB    0
`define ECCE_CFG_PTRB_LSB    4
`define ECCE_CFG_PTRC_LSB    8
`define ECCE_CFG_SIZE_LSB    12
`define ECCE_CFG_IRQEN_BIT   16
`define ECCE_CFG_RESET       32'h0000_0000

// Status register fields
`define ECCE_STS_BUSY_BIT    0
`define ECCE_STS_DONE_BIT    1

// Command register fields
`define ECCE_CMD_START_BIT   0
`define ECCE_CMD_OP_LSB      8

// Window geometry: 1 kB pages, 32-byte slots
`define ECCE_PAGE_BITS       10
`define ECCE_SLOT_BYTES      32
`define ECCE_SLOT_R          4'ha
`define ECCE_SLOT_S          4'hb

// Operation latency in engine cycles
`define ECCE_OP_CYCLES       100000

`endif

// file: ecce_mem_model.sv
// Data RAM model that records the engine's result writes
`timescale 1ns/1ps
`default_nettype none
module ecce_mem_model
   import ecce_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        wbEn,
   input wire logic [31:0] wbAddr,
   input wire logic [31:0] wbData
);
   logic [31:0]  addrLog [16];
   logic [31:0]  dataLog [16];
   // Operand slots as the host fills them, one 256-bit word per slot
   logic [255:0] opnd    [16];
   // Set by the host once the curve microcode has been copied in
   logic         ucodeReady = 1'b0;
   int           badWb      = 0;
   // Slot from bits 8:5; stale entries show if the base was ignored
   always_ff @(posedge core_clk) begin
      if (wbEn) begin
         addrLog[wbAddr[8:5]] <= wbAddr;
         dataLog[wbAddr[8:5]] <= wbData;
      end
   end
   // A result write before the host has prepared the window is a fault
   always @(posedge core_clk) begin
      if (wbEn === 1'b1 && (ucodeReady !== 1'b1 || opnd[12][255:160] !== 96'h0)) begin
         badWb++;
      end
   end
endmodule : ecce_mem_model
`default_nettype wire

// file: ecce_pkg.sv
// Types shared by the curve engine port
package ecce_pkg;
   typedef enum logic [1:0] {
      ECCE_IDLE  = 2'b00,
      ECCE_RUN   = 2'b01,
      ECCE_WBR   = 2'b10,
      ECCE_WBS   = 2'b11
   } ecce_state_e;

   typedef enum logic [1:0] {
      ECCE_SZ64  = 2'b00,
      ECCE_SZ128 = 2'b01,
      ECCE_SZ256 = 2'b10
   } ecce_size_e;
endpackage : ecce_pkg

// file: ecce_slot_store.sv
// Result slot memory standing in for the engine's writeback path
`timescale 1ns/1ps
`default_nettype none
module ecce_slot_store
   import ecce_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 4
) (
   input  wire logic              core_clk,
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [DATA_W-1:0] wrData,
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic      [DATA_W-1:0] rdData
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // ===========================================
   // Write port and registered read port
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : ecce_slot_store
`default_nettype wire

// file: tb_ecce_host_setup.sv
// Self-checking bench for the curve engine control port
`timescale 1ns/1ps
`default_nettype none
`include "ecce_map.svh"
module tb_ecce_host_setup;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, engineIrq, wbEn, er;
   logic [31:0] prdata, wbAddr, wbData, ptrA, ptrB, ptrC, rd;
   int          err_total = 0, compares = 0, cyc = 0, irqCnt = 0;
   // ==========================================
   // Clock, timeout and event counting
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (engineIrq === 1'b1) irqCnt++;
      if (cyc == 8000) begin
         err_total++;
         stop_test();
      end
   end
   // Short operation keeps the run brief
   ecce_host_setup #(.OP_CYCLES(20), .ADDR_W(32)) dut_u (.core_clk, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .engineIrq, .wbEn, .wbAddr,
      .wbData, .ptrAAddr(ptrA), .ptrBAddr(ptrB), .ptrCAddr(ptrC));
   ecce_mem_model u_mem (.core_clk, .wbEn, .wbAddr, .wbData);
   // ==========================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until ready is sampled at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_regs();
      apb(0, `ECCE_OFF_CONFIG, 0); chk(rd, 32'h0);
      apb(1, `ECCE_OFF_BASEADDR, 32'h2000_07ff);
      apb(0, `ECCE_OFF_BASEADDR, 0); chk(rd, 32'h2000_0400);
      apb(1, `ECCE_OFF_CONFIG, 32'h0001_3321);
      apb(0, `ECCE_OFF_CONFIG, 0); chk(rd, 32'h0001_2321);
      apb(1, 12'h020, 32'h1); chk({31'h0, er}, 32'h1);
      $display("t_regs done");
   endtask : t_regs
   // Launch with the clock gate off must be ignored
   task automatic t_gate();
      apb(1, `ECCE_OFF_CLKGATE, 0);
      apb(1, `ECCE_OFF_COMMAND, 32'h101);
      apb(0, `ECCE_OFF_STATUS, 0); chk(rd, 32'h0);
      $display("t_gate done");
   endtask : t_gate
   // Host side of the window: microcode copied in, operands placed,
   // slots 0 to 7 zero-padded to the configured width, slot 12 to 160 bits
   task automatic host_prep(input logic [1:0] sz);
      logic [255:0] mask;
      mask = {256{1'b1}} >> (256 - (64 << sz));
      u_mem.ucodeReady = 1'b1;
      for (int i = 0; i < 8; i++) begin
         u_mem.opnd[i] = {8{32'(i + 1)}} & mask;
      end
      u_mem.opnd[12] = {96'h0, {5{32'h5a5a_a5a5}}};
   endtask : host_prep
   task automatic t_op(input logic [1:0] sz);
      logic [31:0] b;
      int          n;
      int          i0;
      b = 32'h2000_0000 + ({30'h0, sz} + 32'h1) * 32'h400;
      i0 = irqCnt;
      apb(1, `ECCE_OFF_CLKGATE, 1);
      apb(1, `ECCE_OFF_BASEADDR, b);
      apb(1, `ECCE_OFF_CONFIG, 32'h321 | {15'h0, sz[0], 2'h0, sz, 12'h0});
      host_prep(sz);
      apb(1, `ECCE_OFF_COMMAND, 32'h101);
      apb(0, `ECCE_OFF_STATUS, 0); chk(rd & 32'h1, 32'h1);
      apb(1, `ECCE_OFF_CONFIG, 32'hfff); // Pointer change in mid-run
      n = 0;
      do begin
         apb(0, `ECCE_OFF_STATUS, 0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      chk(rd, 32'h2);
      chk(ptrA, b + 32'h20);
      chk(ptrB, b + 32'h40);
      chk(ptrC, b + 32'h60);
      chk(u_mem.addrLog[10], b + 32'h140);
      chk(u_mem.addrLog[11], b + 32'h160);
      chk(u_mem.dataLog[10], {22'h0, sz, 8'h01});
      chk(u_mem.dataLog[11], {22'h0, sz, 8'h01});
      chk({31'h0, u_mem.dataLog[11] == 32'h0}, 32'h0);
      chk(u_mem.badWb, 32'h0);
      chk(irqCnt - i0, {31'h0, sz[0]});
      apb(1, `ECCE_OFF_IRQCLR, 1);
      apb(0, `ECCE_OFF_STATUS, 0); chk(rd, 32'h0);
      $display("t_op size %0d done", sz);
   endtask : t_op
   task automatic stop_test();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   // ==========================================
   // Main sequence; every width is run once
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_gate();
      for (int s = 0; s < 3; s++) t_op(s[1:0]);
      stop_test();
   end
endmodule : tb_ecce_host_setup
`default_nettype wire
